// ---- bench/sfdpt_host_model.sv ----
`timescale 1ns/1ps
module sfdpt_host_model (
	// Clock
	input  wire logic        clk,
	// Parameter byte path
	output logic             cfi_rd = 1'b0,
	output logic             cfi_sfdp_space = 1'b0,
	output logic [15:0]      cfi_addr = 16'hFFFF,
	input  wire logic [7:0]  cfi_data,
	input  wire logic        cfi_valid
);
	task rd_byte(input logic sp, input logic [15:0] a, output logic [7:0] d, output logic ok);
		integer n;
		@(posedge clk);
		cfi_rd <= 1'b1;
		cfi_sfdp_space <= sp;
		cfi_addr <= a;
		@(posedge clk);
		cfi_rd <= 1'b0;
		// Released lines show the inverse, not the old value
		cfi_sfdp_space <= ~sp;
		cfi_addr <= ~a;
		ok = 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge clk);
			ok = (cfi_valid === 1'b1);
		end
		d = cfi_data;
	endtask
endmodule

// ---- bench/sfdpt_param_table_assertions.sv ----
`timescale 1ns/1ps
module sfdpt_param_table_assertions (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// Parameter byte path
	input wire logic        cfi_rd,
	input wire logic        cfi_sfdp_space,
	input wire logic [15:0] cfi_addr,
	input wire logic [7:0]  cfi_data,
	input wire logic        cfi_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	valid_follows_a: assert property (cfi_rd |=> cfi_valid) else $error("byte answer missing");
	valid_pulse_a: assert property (!cfi_rd |=> !cfi_valid) else $error("byte answer without request");
	id_byte_a: assert property (cfi_rd && !cfi_sfdp_space && cfi_addr == 16'h0000 |=>
		cfi_data == 8'hA5) else $error("identifier byte wrong");
	len_byte_a: assert property (cfi_rd && !cfi_sfdp_space && cfi_addr == 16'h0001 |=>
		cfi_data == 8'h50) else $error("length byte wrong");
	sfdp_first_a: assert property (cfi_rd && cfi_sfdp_space && cfi_addr == 16'h1120 |=>
		cfi_data == 8'hE7) else $error("first sfdp byte wrong");
	density_top_a: assert property (cfi_rd && !cfi_sfdp_space && cfi_addr == 16'h0009 |=>
		cfi_data == 8'h1F) else $error("density top byte wrong");
	rsv_byte_a: assert property (cfi_rd && !cfi_sfdp_space && cfi_addr == 16'h0015 |=>
		cfi_data == 8'hFF) else $error("reserved byte not all ones");
	hold_data_a: assert property (!cfi_rd |=> $stable(cfi_data)) else $error("byte changed unasked");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
endmodule

bind sfdpt_param_table sfdpt_param_table_assertions u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cfi_rd(cfi_rd), .cfi_sfdp_space(cfi_sfdp_space),
	.cfi_addr(cfi_addr), .cfi_data(cfi_data), .cfi_valid(cfi_valid));

// ---- bench/tb_sfdp_basic_param_table.sv ----
`timescale 1ns/1ps
module tb_sfdp_basic_param_table;
	// ----------------
	// Signals
	// ----------------
	localparam [175:0] TBL = 176'hFFFFFFEEBB043B086B08EB441FFFFFFFFFF3FFE750A5;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cfi_rd;
	logic        cfi_sfdp_space;
	logic [15:0] cfi_addr;
	logic [7:0]  cfi_data;
	logic        cfi_valid;
	integer      bad_count = 0;
	integer      tests_run = 0;
	always #5 clk = ~clk;
	sfdpt_param_table #(.DDR_VARIANT(1'b0), .ENH_LATENCY(1'b0), .CNT_W(16)) dut (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cfi_rd(cfi_rd), .cfi_sfdp_space(cfi_sfdp_space), .cfi_addr(cfi_addr), .cfi_data(cfi_data),
		.cfi_valid(cfi_valid));
	sfdpt_host_model host (.clk(clk), .cfi_rd(cfi_rd), .cfi_sfdp_space(cfi_sfdp_space), .cfi_addr(cfi_addr),
		.cfi_data(cfi_data), .cfi_valid(cfi_valid));
	// ----------------
	// Shared tasks
	// ----------------
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
		integer n;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= wd;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 20) begin
			bad_count++;
			final_report;
		end
	endtask
	task sbyte(input logic sp, input logic [15:0] a, output logic [7:0] d);
		logic ok;
		host.rd_byte(sp, a, d, ok);
		if (!ok) begin
			bad_count++;
			final_report;
		end
	endtask
	function logic [7:0] expb(input int i, input logic ddr, input logic enh);
		if (i == 4 && ddr)
			return 8'hF7;
		if (i == 16 && enh)
			return 8'h80;
		return TBL[i*8 +: 8];
	endfunction
	// ----------------
	// Scenarios
	// ----------------
	task t_serial(input logic ddr, input logic enh);
		logic [7:0] d;
		integer     i;
		for (i = 0; i < 22; i++) begin
			sbyte(1'b0, i[15:0], d);
			chk("rel byte", {24'h0, d}, {24'h0, expb(i, ddr, enh)});
		end
		for (i = 0; i < 20; i++) begin
			sbyte(1'b1, 16'h1120 + i[15:0], d);
			chk("sfdp byte", {24'h0, d}, {24'h0, expb(i + 2, ddr, enh)});
		end
	endtask
	task t_bus;
		logic [31:0] r;
		integer      i;
		// Table reads over the bus, each one idle cycle after the last
		for (i = 0; i < 22; i++) begin
			bus(1'b0, i[5:0], 32'h0, r);
			chk("table word", {24'h0, r[7:0]}, {24'h0, expb(i, 1'b0, 1'b0)});
		end
		bus(1'b0, 6'h28, 32'h0, r);
		chk("dword1", r, 32'hFFF3FFE7);
		bus(1'b0, 6'h29, 32'h0, r);
		chk("dword2", r, 32'h1FFFFFFF);
		bus(1'b0, 6'h2A, 32'h0, r);
		chk("dword3", r, 32'h6B08EB44);
		bus(1'b0, 6'h2B, 32'h0, r);
		chk("dword4", r, 32'hBB043B08);
		bus(1'b0, 6'h2C, 32'h0, r);
		chk("dword5", r, 32'hFFFFFFEE);
	endtask
	task t_ro;
		logic [31:0] r;
		logic [7:0]  d;
		bus(1'b1, 6'h00, 32'h0, r);
		bus(1'b1, 6'h12, 32'h0, r);
		bus(1'b1, 6'h28, 32'h0, r);
		bus(1'b0, 6'h00, 32'h0, r);
		chk("id after write", {24'h0, r[7:0]}, 32'h000000A5);
		sbyte(1'b0, 16'h0012, d);
		chk("dword5 after write", {24'h0, d}, 32'h000000EE);
		sbyte(1'b0, 16'h0012, d);
		chk("repeat read", {24'h0, d}, 32'h000000EE);
		bus(1'b0, 6'h28, 32'h0, r);
		chk("dword1 after write", r, 32'hFFF3FFE7);
		bus(1'b0, 6'h21, 32'h0, r);
		chk("refused flag", {31'h0, r[2]}, 32'h1);
		bus(1'b0, 6'h3F, 32'h0, r);
		chk("unmapped", r, 32'h0);
		bus(1'b0, 6'h24, 32'h0, r);
		chk("next param", r, 32'h00000052);
		bus(1'b0, 6'h22, 32'h0, r);
		chk("read count", r, 32'h00000043);
		bus(1'b0, 6'h23, 32'h0, r);
		chk("refused count", r, 32'h00000002);
		bus(1'b1, 6'h21, 32'h4, r);
		bus(1'b1, 6'h23, 32'h0, r);
		bus(1'b0, 6'h21, 32'h0, r);
		chk("status cleared", r, 32'h00001200);
		bus(1'b0, 6'h23, 32'h0, r);
		chk("count cleared", r, 32'h0);
	endtask
	task t_variant;
		logic [31:0] r;
		bus(1'b1, 6'h20, 32'h3, r);
		bus(1'b0, 6'h20, 32'h0, r);
		chk("ctrl readback", r, 32'h3);
		t_serial(1'b1, 1'b1);
		bus(1'b1, 6'h20, 32'h1, r);
		bus(1'b0, 6'h28, 32'h0, r);
		chk("dword1 ddr", r, 32'hFFF7FFE7);
		bus(1'b1, 6'h20, 32'h2, r);
		bus(1'b0, 6'h2B, 32'h0, r);
		chk("dword4 enhanced", r, 32'hBB803B08);
		bus(1'b1, 6'h20, 32'h0, r);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_serial(1'b0, 1'b0);
		t_bus;
		t_ro;
		t_variant;
		final_report;
	end
endmodule

// ---- core/sfdpt_param_table.v ----
`timescale 1ns/1ps
`include "sfdpt_map.vh"

// Behaviour
// - Offset 00h returns identifier A5h
// - Offset 01h returns length 50h
// - First SFDP byte at 1120h reads E7h
// - 4 KB erase unavailable: 11b, opcode FFh
// - Dword1 byte2 F3h, or F7h with DDR
// - Three-or-four byte address, dual/quad reads flagged
// - Density 1FFFFFFFh, least significant byte first
// - Quad I/O read encodes 44h then EBh
// - Quad output read encodes 08h then 6Bh
// - Dual output read encodes 08h then 3Bh
// - Dual I/O BBh: 80h enhanced, 04h standard
// - Dword5 byte0 EEh: no all-quad, no all-dual
// - Reserved bytes and unused serial addresses read FFh; unmapped bus words read 0
module sfdpt_param_table #(
	parameter DDR_VARIANT = 1'b0,
	parameter ENH_LATENCY = 1'b0,
	parameter CNT_W       = 16
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Avalon-MM slave, word addressed
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Parameter byte read path from the serial engine
	input  wire        cfi_rd,
	input  wire        cfi_sfdp_space,
	input  wire [15:0] cfi_addr,
	output reg  [7:0]  cfi_data,
	output reg         cfi_valid
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg              ddr_q;
	reg              enh_q;
	reg              refused_q;
	reg  [7:0]       last_off_q;
	reg  [31:0]      rd_mux;
	reg  [7:0]       cfi_byte;
	reg              cfi_hit;
	reg  [4:0]       cfi_off;

	wire [175:0]     table_flat;
	wire [7:0]       tbl_byte [0:`SFDPT_TBL_LEN-1];
	wire [31:0]      dw_word [0:`SFDPT_DW_COUNT-1];
	wire [CNT_W-1:0] rd_cnt;
	wire [CNT_W-1:0] wr_cnt;

	wire             req;
	wire             fire;
	wire             wr_fire;
	wire             rd_fire;
	wire             tbl_sel;
	wire             dw_sel;
	wire [5:0]       dw_rel;
	wire [15:0]      sfdp_rel;
	wire             refuse_ev;
	wire             tbl_rd_ev;
	wire             st_clr;
	wire             wrcnt_clr;

	// ----------------------------------------
	// Constant table and its views
	// ----------------------------------------
	sfdpt_rom u_rom (
		.ddr_sel    (ddr_q),
		.enh_sel    (enh_q),
		.table_flat (table_flat)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `SFDPT_TBL_LEN; gi = gi + 1) begin : g_byte
			assign tbl_byte[gi] = table_flat[gi*8 +: 8];
		end
		// SFDP dwords start two bytes into the wrapper
		for (gi = 0; gi < `SFDPT_DW_COUNT; gi = gi + 1) begin : g_dword
			assign dw_word[gi] = table_flat[16 + gi*32 +: 32];
		end
	endgenerate

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	assign req     = avs_read | avs_write;
	assign fire    = req & ~avs_waitrequest;
	assign wr_fire = avs_write & ~avs_waitrequest;
	assign rd_fire = avs_read & ~avs_waitrequest;
	assign tbl_sel = (avs_address < `SFDPT_TBL_LEN);
	assign dw_rel  = avs_address - `SFDPT_IDX_DW_BASE;
	assign dw_sel  = (avs_address >= `SFDPT_IDX_DW_BASE) && (dw_rel < `SFDPT_DW_COUNT);

	// One wait cycle: data is prepared while waitrequest is high,
	// so the word stands at the edge where the master sees it low
	always @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			if (avs_read)
				avs_readdata <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always @* begin
		rd_mux = 32'h00000000;
		if (tbl_sel) begin
			rd_mux = {24'h000000, tbl_byte[avs_address[4:0]]};
		end else if (dw_sel) begin
			rd_mux = dw_word[dw_rel[2:0]];
		end else begin
			case (avs_address)
				`SFDPT_IDX_CTRL: begin
					rd_mux[`SFDPT_CTRL_DDR] = ddr_q;
					rd_mux[`SFDPT_CTRL_ENH] = enh_q;
				end
				`SFDPT_IDX_STATUS: begin
					rd_mux[`SFDPT_CTRL_DDR]   = ddr_q;
					rd_mux[`SFDPT_CTRL_ENH]   = enh_q;
					rd_mux[`SFDPT_ST_REFUSED] = refused_q;
					rd_mux[15:8]              = last_off_q;
				end
				`SFDPT_IDX_RDCNT:  rd_mux[CNT_W-1:0] = rd_cnt;
				`SFDPT_IDX_WRCNT:  rd_mux[CNT_W-1:0] = wr_cnt;
				`SFDPT_IDX_NEXT:   rd_mux[7:0]       = `SFDPT_NEXT_PARAM;
				default:           rd_mux            = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Variant control and status
	// ----------------------------------------
	// Table bytes themselves are never stored, so a write there is only counted and flagged in the refused bit
	assign refuse_ev = wr_fire & tbl_sel;
	assign tbl_rd_ev = rd_fire & tbl_sel;
	assign st_clr    = wr_fire && (avs_address == `SFDPT_IDX_STATUS) && avs_byteenable[0]
	                   && avs_writedata[`SFDPT_ST_REFUSED];
	assign wrcnt_clr = wr_fire && (avs_address == `SFDPT_IDX_WRCNT);

	always @(posedge clk) begin
		if (rst) begin
			ddr_q     <= DDR_VARIANT;
			enh_q     <= ENH_LATENCY;
			refused_q <= 1'b0;
		end else begin
			if (wr_fire && (avs_address == `SFDPT_IDX_CTRL) && avs_byteenable[0]) begin
				ddr_q <= avs_writedata[`SFDPT_CTRL_DDR];
				enh_q <= avs_writedata[`SFDPT_CTRL_ENH];
			end
			// Set beats a clear in the same cycle
			if (refuse_ev)
				refused_q <= 1'b1;
			else if (st_clr)
				refused_q <= 1'b0;
		end
	end

	sfdpt_sat_cnt #(
		.WIDTH (CNT_W)
	) u_rd_cnt (
		.clk   (clk),
		.rst   (rst),
		.clr   (1'b0),
		.inc   ({1'b0, tbl_rd_ev} + {1'b0, cfi_rd}),
		.cnt_q (rd_cnt)
	);

	sfdpt_sat_cnt #(
		.WIDTH (CNT_W)
	) u_wr_cnt (
		.clk   (clk),
		.rst   (rst),
		.clr   (wrcnt_clr),
		.inc   ({1'b0, refuse_ev}),
		.cnt_q (wr_cnt)
	);

	// ----------------------------------------
	// Serial read path
	// ----------------------------------------
	assign sfdp_rel = cfi_addr - `SFDPT_SFDP_BASE;

	always @* begin
		cfi_hit = 1'b0;
		cfi_off = 5'h00;
		if (cfi_sfdp_space) begin
			if ((cfi_addr >= `SFDPT_SFDP_BASE) && (sfdp_rel < `SFDPT_SFDP_LEN)) begin
				cfi_hit = 1'b1;
				cfi_off = sfdp_rel[4:0] + `SFDPT_SFDP_SKEW;
			end
		end else if (cfi_addr < `SFDPT_TBL_LEN) begin
			cfi_hit = 1'b1;
			cfi_off = cfi_addr[4:0];
		end
		// Outside the table the bus floats high, as erased flash would
		cfi_byte = cfi_hit ? tbl_byte[cfi_off] : `SFDPT_RSV_BYTE;
	end

	always @(posedge clk) begin
		if (rst) begin
			cfi_data   <= 8'hFF;
			cfi_valid  <= 1'b0;
			last_off_q <= 8'h00;
		end else begin
			cfi_valid <= cfi_rd;
			if (cfi_rd) begin
				cfi_data   <= cfi_byte;
				last_off_q <= {3'h0, cfi_off};
			end
		end
	end

endmodule

// ---- core/sfdpt_rom.v ----
`timescale 1ns/1ps
`include "sfdpt_map.vh"

module sfdpt_rom (
	// Variant selects
	input  wire         ddr_sel,
	input  wire         enh_sel,
	// Whole table, byte 0 in the low bits
	output wire [175:0] table_flat
);

	wire [7:0] d1_b0;
	wire [7:0] d1_b2;
	wire [7:0] dio_b;
	wire [7:0] d5_b0;

	assign d1_b0 = {`SFDPT_D1_UNUSED3, `SFDPT_D1_SRWR, `SFDPT_D1_BUF64, `SFDPT_D1_ERASE4K};
	// DDR variant must read F7h, so its flag lands in bit 2 of this byte
	assign d1_b2 = {`SFDPT_D1_RDCAP, 1'b0, `SFDPT_D1_ADDR34, `SFDPT_D1_DUALOUT}
	               | {5'h00, ddr_sel, 2'h0};
	assign dio_b = enh_sel ? {`SFDPT_DIO_MODE_ENH, `SFDPT_DIO_DUMMY_ENH}
	                       : {`SFDPT_DIO_MODE_STD, `SFDPT_DIO_DUMMY_STD};
	assign d5_b0 = {`SFDPT_D5_RSV_HI, `SFDPT_D5_QUADALL, `SFDPT_D5_RSV_LO, `SFDPT_D5_DUALALL};

	// Pure wiring of constants: nothing here can be written
	assign table_flat = {
		{3{`SFDPT_RSV_BYTE}}, d5_b0,
		`SFDPT_DIO_OP, dio_b,
		`SFDPT_DO_OP, {`SFDPT_DO_MODE, `SFDPT_DO_DUMMY},
		`SFDPT_QO_OP, {`SFDPT_QO_MODE, `SFDPT_QO_DUMMY},
		`SFDPT_QIO_OP, {`SFDPT_QIO_MODE, `SFDPT_QIO_DUMMY},
		`SFDPT_DENSITY,
		`SFDPT_D1_TOP, d1_b2, `SFDPT_D1_OP4K, d1_b0,
		`SFDPT_PARAM_LEN, `SFDPT_PARAM_ID
	};

endmodule

// ---- core/sfdpt_sat_cnt.v ----
`timescale 1ns/1ps

module sfdpt_sat_cnt #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Control
	input  wire             clr,
	input  wire [1:0]       inc,
	// Count
	output reg  [WIDTH-1:0] cnt_q
);

	wire [WIDTH:0] sum;

	assign sum = {1'b0, cnt_q} + {{(WIDTH-1){1'b0}}, inc};

	// A clear with an increment in the same cycle restarts the count at inc unless the sum overflows; saturates at all ones
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {WIDTH{1'b0}};
		end else if (inc != 2'h0) begin
			if (sum[WIDTH])
				cnt_q <= {WIDTH{1'b1}};
			else if (clr)
				cnt_q <= {{(WIDTH-2){1'b0}}, inc};
			else
				cnt_q <= sum[WIDTH-1:0];
		end else if (clr) begin
			cnt_q <= {WIDTH{1'b0}};
		end
	end

endmodule

// ---- inc/sfdpt_map.vh ----
`ifndef SFDPT_MAP_VH
`define SFDPT_MAP_VH

// ----------------------------------------
// Table geometry
// ----------------------------------------
`define SFDPT_TBL_LEN       22
`define SFDPT_SFDP_LEN      20
`define SFDPT_SFDP_SKEW     5'h02
`define SFDPT_SFDP_BASE     16'h1120
`define SFDPT_NEXT_PARAM    8'h52

// ----------------------------------------
// Wrapper header bytes
// ----------------------------------------
`define SFDPT_PARAM_ID      8'hA5
`define SFDPT_PARAM_LEN     8'h50

// ----------------------------------------
// Dword 1 fields
// ----------------------------------------
`define SFDPT_D1_UNUSED3    3'h7
`define SFDPT_D1_SRWR       2'h0
`define SFDPT_D1_BUF64      1'h1
`define SFDPT_D1_ERASE4K    2'h3
`define SFDPT_D1_OP4K       8'hFF
`define SFDPT_D1_RDCAP      4'hF
`define SFDPT_D1_ADDR34     2'h1
`define SFDPT_D1_DUALOUT    1'h1
`define SFDPT_D1_TOP        8'hFF

// ----------------------------------------
// Density, dword 2, least significant first
// ----------------------------------------
`define SFDPT_DENSITY       32'h1FFFFFFF

// ----------------------------------------
// Dwords 3 and 4: mode cycles, dummy cycles, opcode
// ----------------------------------------
`define SFDPT_QIO_MODE      3'h2
`define SFDPT_QIO_DUMMY     5'h04
`define SFDPT_QIO_OP        8'hEB
`define SFDPT_QO_MODE       3'h0
`define SFDPT_QO_DUMMY      5'h08
`define SFDPT_QO_OP         8'h6B
`define SFDPT_DO_MODE       3'h0
`define SFDPT_DO_DUMMY      5'h08
`define SFDPT_DO_OP         8'h3B
`define SFDPT_DIO_MODE_ENH  3'h4
`define SFDPT_DIO_DUMMY_ENH 5'h00
`define SFDPT_DIO_MODE_STD  3'h0
`define SFDPT_DIO_DUMMY_STD 5'h04
`define SFDPT_DIO_OP        8'hBB

// ----------------------------------------
// Dword 5
// ----------------------------------------
`define SFDPT_D5_RSV_HI     3'h7
`define SFDPT_D5_QUADALL    1'h0
`define SFDPT_D5_RSV_LO     3'h7
`define SFDPT_D5_DUALALL    1'h0
`define SFDPT_RSV_BYTE      8'hFF

// ----------------------------------------
// Bus word indices (byte address is four times)
// ----------------------------------------
`define SFDPT_IDX_CTRL      6'h20
`define SFDPT_IDX_STATUS    6'h21
`define SFDPT_IDX_RDCNT     6'h22
`define SFDPT_IDX_WRCNT     6'h23
`define SFDPT_IDX_NEXT      6'h24
`define SFDPT_IDX_DW_BASE   6'h28
`define SFDPT_DW_COUNT      5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFDPT_CTRL_DDR      0
`define SFDPT_CTRL_ENH      1
`define SFDPT_ST_REFUSED    2

`endif
